// File: verilog/uxr_ext_regs.sv
// Extended register bank of one UART channel on the 8-bit host bus.
// Assumes bus strobes synchronous to clk and FIFO counts from the datapath.
`timescale 1ns/1ps
`include "uxr_consts.svh"

module uxr_ext_regs #(
  parameter int CHANNEL = 0  // Index of this channel in the ready byte
) (
  input  wire logic                   clk,            // System clock
  input  wire logic                   rstn,           // Asynchronous reset, active low
  input  wire logic                   chanSelectN,    // Channel select, active low
  input  wire logic [2:0]             addr,           // Register offset
  input  wire logic                   wrN,            // Write strobe, active low
  input  wire logic                   rdN,            // Read strobe, active low
  input  wire uxr_pkg::uxr_byte_type  wrData,         // Write data
  output uxr_pkg::uxr_byte_type       rdData,         // Registered read data
  input  wire uxr_pkg::uxr_level_type rxCount,        // Receive FIFO fill
  input  wire uxr_pkg::uxr_level_type txSpace,        // Transmit FIFO free spaces
  input  wire logic                   rxTimeout,      // Receive time-out seen
  input  wire logic [3:0]             peerRxReady,    // Receive ready of all channels
  input  wire logic [3:0]             peerTxReady,    // Transmit ready of all channels
  output logic                        rxReady,        // This channel receive ready
  output logic                        txReady,        // This channel transmit ready
  output logic                        rtsN,           // Request-to-send pin, active low
  output logic [15:0]                 baudDivisor,    // Baud generator divisor
  output logic                        sleepEnable,    // Sleep mode requested
  output logic                        loopback,       // Internal loop-back on
  output uxr_pkg::uxr_byte_type       flowMode,       // Enhanced feature byte
  output uxr_pkg::uxr_byte_type       resumeChar1,    // First resume character
  output uxr_pkg::uxr_byte_type       resumeChar2,    // Second resume character
  output uxr_pkg::uxr_byte_type       pauseChar1,     // First pause character
  output uxr_pkg::uxr_byte_type       pauseChar2,     // Second pause character
  output uxr_pkg::uxr_level_type      rxTrigger,      // Effective receive trigger
  output uxr_pkg::uxr_level_type      txTrigger       // Effective transmit trigger
);
  import uxr_pkg::*;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  uxr_byte_type   divLo_q, divHi_q, ier_q, fcr_q, efr_q, lcr_q, mcr_q;
  uxr_byte_type   flow_resume_char_one_q, flow_resume_char_two_q, flow_pause_char_one_q, flow_pause_char_two_q, tcr_q, tlr_q;
  uxr_byte_type   rdData_q, rdData_d;
  logic           wrN_q, wrPulse, enhOn, rdyOpen;
  uxr_target_type target;
  uxr_byte_type   readyByte;
  logic           rxReady_q, txReady_q;
  uxr_level_type  rxTrigger_q, txTrigger_q;

  uxr_level_if rxLvl ();
  uxr_level_if txLvl ();
  uxr_flow_if  flow ();

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // One write per strobe fall, so a long strobe cannot write twice
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrN_q <= 1'b1;
    end else begin
      wrN_q <= wrN;
    end
  end

  assign wrPulse = !chanSelectN && !wrN && wrN_q;
  assign enhOn   = efr_q[`UXR_EFR_ENH_BIT];
  assign rdyOpen = mcr_q[`UXR_MCR_RDY_BIT] && !mcr_q[`UXR_MCR_LOOP_BIT];

  // Bank selection from line and modem control
  always_comb begin
    target = TGT_NONE;
    if (lcr_q == `UXR_LINE_ENH_KEY) begin
      unique case (addr)
        `UXR_OFF_DIV_LO: target = TGT_DIV_LO;
        `UXR_OFF_DIV_HI: target = TGT_DIV_HI;
        `UXR_OFF_CTRL2:  target = TGT_EFR;
        `UXR_OFF_LINE:   target = TGT_LCR;
        `UXR_OFF_MODEM:  target = TGT_FLOW_RESUME_CHAR_ONE;
        `UXR_OFF_CHAR5:  target = TGT_FLOW_RESUME_CHAR_TWO;
        `UXR_OFF_THRESH: target = TGT_FLOW_PAUSE_CHAR_ONE;
        `UXR_OFF_LEVEL:  target = TGT_FLOW_PAUSE_CHAR_TWO;
      endcase
    end else begin
      unique case (addr)
        `UXR_OFF_DIV_LO: target = lcr_q[`UXR_LINE_DIV_BIT] ? TGT_DIV_LO : TGT_NONE;
        `UXR_OFF_DIV_HI: target = lcr_q[`UXR_LINE_DIV_BIT] ? TGT_DIV_HI : TGT_IER;
        `UXR_OFF_CTRL2:  target = TGT_FCR;
        `UXR_OFF_LINE:   target = TGT_LCR;
        `UXR_OFF_MODEM:  target = TGT_MCR;
        `UXR_OFF_CHAR5:  target = TGT_NONE;
        `UXR_OFF_THRESH: target = mcr_q[`UXR_MCR_BANK_BIT] ? TGT_TCR : TGT_NONE;
        `UXR_OFF_LEVEL:  target = mcr_q[`UXR_MCR_BANK_BIT] ? TGT_TLR : (rdyOpen ? TGT_RDY : TGT_NONE);
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Divisor, line and interrupt enable
  // --------------------------------------------------------------------------
  // Divisor frozen while sleep is enabled; clock stays stable asleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divLo_q <= `UXR_RST_BYTE;
      divHi_q <= `UXR_RST_BYTE;
    end else if (wrPulse && !ier_q[`UXR_IER_SLEEP_BIT]) begin
      if (target == TGT_DIV_LO) begin
        divLo_q <= wrData;
      end
      if (target == TGT_DIV_HI) begin
        divHi_q <= wrData;
      end
    end
  end

  // Line control selects the banks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lcr_q <= `UXR_RST_LINE;
    end else if (wrPulse && target == TGT_LCR) begin
      lcr_q <= wrData;
    end
  end

  // Upper enable bits only move with the enhanced bit set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ier_q <= `UXR_RST_BYTE;
    end else if (wrPulse && target == TGT_IER) begin
      ier_q <= {enhOn ? wrData[7:4] : ier_q[7:4], wrData[3:0]};
    end
  end

  // --------------------------------------------------------------------------
  // FIFO, enhanced and modem control
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fcr_q <= `UXR_RST_BYTE;
    end else if (wrPulse && target == TGT_FCR) begin
      fcr_q <= {wrData[7:6], enhOn ? wrData[5:4] : fcr_q[5:4], wrData[3:0]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      efr_q <= `UXR_RST_BYTE;
    end else if (wrPulse && target == TGT_EFR) begin
      efr_q <= wrData;
    end
  end

  // Bank bit itself is guarded, so the extended bank needs both keys
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mcr_q <= `UXR_RST_BYTE;
    end else if (wrPulse && target == TGT_MCR) begin
      mcr_q <= {enhOn ? wrData[7:5] : mcr_q[7:5], wrData[4:0]};
    end
  end

  // --------------------------------------------------------------------------
  // Flow characters
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flow_resume_char_one_q  <= `UXR_RST_BYTE;
      flow_resume_char_two_q  <= `UXR_RST_BYTE;
      flow_pause_char_one_q <= `UXR_RST_BYTE;
      flow_pause_char_two_q <= `UXR_RST_BYTE;
    end else if (wrPulse) begin
      if (target == TGT_FLOW_RESUME_CHAR_ONE) begin
        flow_resume_char_one_q <= wrData;
      end
      if (target == TGT_FLOW_RESUME_CHAR_TWO) begin
        flow_resume_char_two_q <= wrData;
      end
      if (target == TGT_FLOW_PAUSE_CHAR_ONE) begin
        flow_pause_char_one_q <= wrData;
      end
      if (target == TGT_FLOW_PAUSE_CHAR_TWO) begin
        flow_pause_char_two_q <= wrData;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Threshold and trigger level registers
  // --------------------------------------------------------------------------
  // Ignored silently when either key is missing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tcr_q <= `UXR_RST_BYTE;
      tlr_q <= `UXR_RST_BYTE;
    end else if (wrPulse && enhOn && mcr_q[`UXR_MCR_BANK_BIT]) begin
      if (target == TGT_TCR) begin
        tcr_q <= wrData;
      end
      if (target == TGT_TLR) begin
        tlr_q <= wrData;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Trigger selection and flow gate
  // --------------------------------------------------------------------------
  assign rxLvl.field  = tlr_q[7:4];
  assign rxLvl.fcrSel = fcr_q[`UXR_FCR_RX_LSB +: 2];
  assign txLvl.field  = tlr_q[3:0];
  assign txLvl.fcrSel = fcr_q[`UXR_FCR_TX_LSB +: 2];

  uxr_trigger_select #(.LEVEL0(`UXR_RX_LVL0), .LEVEL1(`UXR_RX_LVL1), .LEVEL2(`UXR_RX_LVL2), .LEVEL3(`UXR_RX_LVL3))
    rxSelect (.lvl(rxLvl));

  uxr_trigger_select #(.LEVEL0(`UXR_TX_LVL0), .LEVEL1(`UXR_TX_LVL1), .LEVEL2(`UXR_TX_LVL2), .LEVEL3(`UXR_TX_LVL3))
    txSelect (.lvl(txLvl));

  // Fields count in fours; halt above resume is the host's duty
  assign flow.enable      = efr_q[`UXR_EFR_RTS_BIT];
  assign flow.mcrRts      = mcr_q[`UXR_MCR_RTS_BIT];
  assign flow.rxCount     = rxCount;
  assign flow.haltLevel   = {1'b0, tcr_q[3:0], 2'b00};
  assign flow.resumeLevel = {1'b0, tcr_q[7:4], 2'b00};

  uxr_flow_gate flowGate (
    .clk  (clk),
    .rstn (rstn),
    .flow (flow)
  );

  // --------------------------------------------------------------------------
  // FIFO ready status
  // --------------------------------------------------------------------------
  // Registered each cycle, so status is at most one cycle old
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxReady_q   <= 1'b0;
      txReady_q   <= 1'b0;
      rxTrigger_q <= 7'h00;
      txTrigger_q <= 7'h00;
    end else begin
      rxReady_q   <= (rxCount > rxLvl.level) || rxTimeout;
      txReady_q   <= txSpace >= txLvl.level;
      rxTrigger_q <= rxLvl.level;
      txTrigger_q <= txLvl.level;
    end
  end

  // Own channel bit replaces the peer copy
  always_comb begin
    readyByte = {peerRxReady, peerTxReady};
    readyByte[4 + CHANNEL] = rxReady_q;
    readyByte[CHANNEL]     = txReady_q;
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (target)
      TGT_DIV_LO: rdData_d = divLo_q;
      TGT_DIV_HI: rdData_d = divHi_q;
      TGT_IER:    rdData_d = ier_q;
      TGT_EFR:    rdData_d = efr_q;
      TGT_LCR:    rdData_d = lcr_q;
      TGT_MCR:    rdData_d = mcr_q;
      TGT_FLOW_RESUME_CHAR_ONE:   rdData_d = flow_resume_char_one_q;
      TGT_FLOW_RESUME_CHAR_TWO:   rdData_d = flow_resume_char_two_q;
      TGT_FLOW_PAUSE_CHAR_ONE:  rdData_d = flow_pause_char_one_q;
      TGT_FLOW_PAUSE_CHAR_TWO:  rdData_d = flow_pause_char_two_q;
      TGT_TCR:    rdData_d = tcr_q;
      TGT_TLR:    rdData_d = rdyOpen ? readyByte : tlr_q;
      TGT_RDY:    rdData_d = readyByte;
      default:    rdData_d = 8'h00;
    endcase
  end

  // Data follows the strobe while held, holds after it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 8'h00;
    end else if (!chanSelectN && !rdN) begin
      rdData_q <= rdData_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rdData      = rdData_q;
  assign rxReady     = rxReady_q;
  assign txReady     = txReady_q;
  assign rtsN        = flow.rtsN;
  assign baudDivisor = {divHi_q, divLo_q};
  assign sleepEnable = ier_q[`UXR_IER_SLEEP_BIT];
  assign loopback    = mcr_q[`UXR_MCR_LOOP_BIT];
  assign flowMode    = efr_q;
  assign resumeChar1 = flow_resume_char_one_q;
  assign resumeChar2 = flow_resume_char_two_q;
  assign pauseChar1  = flow_pause_char_one_q;
  assign pauseChar2  = flow_pause_char_two_q;
  assign rxTrigger   = rxTrigger_q;
  assign txTrigger   = txTrigger_q;

endmodule

// File: verilog/uxr_consts.svh
// Constants of the extended UART register bank: offsets, field positions,
// reset values and default FIFO trigger levels.
// Assumes inclusion by bare name from every file that needs them.
`ifndef UXR_CONSTS_SVH
`define UXR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UXR_OFF_DIV_LO      3'h0
`define UXR_OFF_DIV_HI      3'h1
`define UXR_OFF_CTRL2       3'h2
`define UXR_OFF_LINE        3'h3
`define UXR_OFF_MODEM       3'h4
`define UXR_OFF_CHAR5       3'h5
`define UXR_OFF_THRESH      3'h6
`define UXR_OFF_LEVEL       3'h7

// ----------------------------------------------------------------------------
// Bank keys and field positions
// ----------------------------------------------------------------------------
`define UXR_LINE_ENH_KEY    8'hBF
`define UXR_LINE_DIV_BIT    7
`define UXR_EFR_RTS_BIT     6
`define UXR_EFR_ENH_BIT     4
`define UXR_IER_SLEEP_BIT   4
`define UXR_MCR_BANK_BIT    6
`define UXR_MCR_LOOP_BIT    4
`define UXR_MCR_RDY_BIT     2
`define UXR_MCR_RTS_BIT     1
`define UXR_FCR_RX_LSB      6
`define UXR_FCR_TX_LSB      4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UXR_RST_BYTE        8'h00
`define UXR_RST_LINE        8'h00

// ----------------------------------------------------------------------------
// Trigger levels selected through the FIFO control bits
// ----------------------------------------------------------------------------
`define UXR_RX_LVL0         7'h08
`define UXR_RX_LVL1         7'h10
`define UXR_RX_LVL2         7'h38
`define UXR_RX_LVL3         7'h3C
`define UXR_TX_LVL0         7'h08
`define UXR_TX_LVL1         7'h10
`define UXR_TX_LVL2         7'h20
`define UXR_TX_LVL3         7'h38

`endif

// File: verilog/uxr_pkg.sv
// Types shared by the extended UART register bank modules.
// Assumes nothing of its surroundings.
package uxr_pkg;

  typedef logic [7:0] uxr_byte_type;
  typedef logic [6:0] uxr_level_type;

  // Register reached by the current address and bank settings
  typedef enum logic [3:0] {
    TGT_NONE   = 4'h0,
    TGT_DIV_LO = 4'h1,
    TGT_DIV_HI = 4'h2,
    TGT_IER    = 4'h3,
    TGT_FCR    = 4'h4,
    TGT_EFR    = 4'h5,
    TGT_LCR    = 4'h6,
    TGT_MCR    = 4'h7,
    TGT_FLOW_RESUME_CHAR_ONE   = 4'h8,
    TGT_FLOW_RESUME_CHAR_TWO   = 4'h9,
    TGT_FLOW_PAUSE_CHAR_ONE  = 4'hA,
    TGT_FLOW_PAUSE_CHAR_TWO  = 4'hB,
    TGT_TCR    = 4'hC,
    TGT_TLR    = 4'hD,
    TGT_RDY    = 4'hE
  } uxr_target_type;

endpackage

// File: verilog/uxr_if.sv
// Interfaces between the register bank and its trigger and flow helpers.
// Assumes the owner drives the settings and the helper the result.
`timescale 1ns/1ps

// Trigger level selection: programmed field or fallback selector
interface uxr_level_if;
  logic [3:0] field;
  logic [1:0] fcrSel;
  logic [6:0] level;
  modport owner (output field, output fcrSel, input level);
  modport calc  (input field, input fcrSel, output level);
endinterface

// Request-to-send hysteresis between halt and resume levels
interface uxr_flow_if;
  logic       enable;
  logic       mcrRts;
  logic [6:0] rxCount;
  logic [6:0] haltLevel;
  logic [6:0] resumeLevel;
  logic       rtsN;
  modport owner (output enable, output mcrRts, output rxCount, output haltLevel,
                 output resumeLevel, input rtsN);
  modport gate  (input enable, input mcrRts, input rxCount, input haltLevel,
                 input resumeLevel, output rtsN);
endinterface

// File: verilog/uxr_trigger_select.sv
// Effective FIFO trigger level for one direction.
// Assumes the owner supplies the 4-bit programmed field and 2-bit selector.
`timescale 1ns/1ps
`include "uxr_consts.svh"

module uxr_trigger_select #(
  parameter logic [6:0] LEVEL0 = `UXR_RX_LVL0,
  parameter logic [6:0] LEVEL1 = `UXR_RX_LVL1,
  parameter logic [6:0] LEVEL2 = `UXR_RX_LVL2,
  parameter logic [6:0] LEVEL3 = `UXR_RX_LVL3
) (
  uxr_level_if.calc lvl  // Field, selector and resulting level
);
  import uxr_pkg::*;

  // A zero field falls back to the selector table
  always_comb begin
    unique case (lvl.fcrSel)
      2'b00: lvl.level = LEVEL0;
      2'b01: lvl.level = LEVEL1;
      2'b10: lvl.level = LEVEL2;
      2'b11: lvl.level = LEVEL3;
    endcase
    if (lvl.field != 4'h0) begin
      lvl.level = {1'b0, lvl.field, 2'b00};  // Field counts in fours
    end
  end

endmodule

// File: verilog/uxr_flow_gate.sv
// Request-to-send hysteresis driven by receive FIFO occupancy.
// Assumes halt level above resume level; nothing here checks it.
`timescale 1ns/1ps

module uxr_flow_gate (
  input  wire logic clk,   // System clock
  input  wire logic rstn,  // Asynchronous reset, active low
  uxr_flow_if.gate  flow   // Levels in, pin level out
);
  import uxr_pkg::*;

  logic rtsN_q;

  // Halt wins over resume when levels are misprogrammed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rtsN_q <= 1'b1;
    end else if (!flow.enable) begin
      rtsN_q <= ~flow.mcrRts;
    end else if (flow.rxCount >= flow.haltLevel) begin
      rtsN_q <= 1'b1;
    end else if (flow.rxCount <= flow.resumeLevel) begin
      rtsN_q <= 1'b0;
    end
  end

  assign flow.rtsN = rtsN_q;

endmodule

// File: verification/uxr_host_model.sv
// Host processor model on the channel's 8-bit register bus.
// Assumes one clock; the bench calls its tasks one at a time.
`timescale 1ns/1ps

module uxr_host_model (
  input  wire logic                  clk,          // System clock
  input  wire uxr_pkg::uxr_byte_type rdData,       // Read data
  output logic                       chanSelectN,  // Channel select, active low
  output logic [2:0]                 addr,         // Register offset
  output logic                       wrN,          // Write strobe, active low
  output logic                       rdN,          // Read strobe, active low
  output uxr_pkg::uxr_byte_type      wrData        // Write data
);
  import uxr_pkg::*;

  // ------
  // Bus cycles
  // ------
  // Idle bus at time zero
  initial begin
    chanSelectN = 1'b1;
    addr        = 3'h0;
    wrN         = 1'b1;
    rdN         = 1'b1;
    wrData      = 8'h00;
  end

  // Strobe held over one edge; released data shows its inverse, not stale
  task automatic wr(input logic [2:0] a, input uxr_byte_type d);
    @(posedge clk);
    #1;
    chanSelectN = 1'b0;
    addr        = a;
    wrData      = d;
    wrN         = 1'b0;
    @(posedge clk);
    #1;
    wrN         = 1'b1;
    chanSelectN = 1'b1;
    wrData      = ~d;
  endtask

  // Data is taken just after the edge that samples the read
  task automatic rd(input logic [2:0] a, output uxr_byte_type d);
    @(posedge clk);
    #1;
    chanSelectN = 1'b0;
    addr        = a;
    rdN         = 1'b0;
    @(posedge clk);
    #1;
    d           = rdData;
    rdN         = 1'b1;
    chanSelectN = 1'b1;
  endtask

  // Open the extended bank: enhanced byte under key, then modem byte
  task automatic ext_bank(input uxr_byte_type enhanced_feature_control, input uxr_byte_type modem_control);
    wr(3'h3, 8'hBF);
    wr(3'h2, enhanced_feature_control);
    wr(3'h3, 8'h00);
    wr(3'h4, modem_control);
  endtask
endmodule

// File: verification/uxr_ext_regs_monitor.sv
// Checker for the extended register bank, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps

module uxr_ext_regs_monitor (
  input wire logic                   clk,          // System clock
  input wire logic                   rstn,         // Reset, active low
  input wire logic                   chanSelectN,  // Channel select, active low
  input wire logic [2:0]             addr,         // Register offset
  input wire logic                   wrN,          // Write strobe, active low
  input wire uxr_pkg::uxr_level_type rxCount,      // Receive fill
  input wire uxr_pkg::uxr_level_type txSpace,      // Transmit free spaces
  input wire logic                   rxTimeout,    // Receive time-out
  input wire logic                   rxReady,      // Receive ready
  input wire logic                   txReady,      // Transmit ready
  input wire logic [15:0]            baudDivisor,  // Divisor
  input wire logic                   sleepEnable,  // Sleep requested
  input wire uxr_pkg::uxr_byte_type  flowMode,     // Enhanced byte
  input wire uxr_pkg::uxr_byte_type  resumeChar1,  // First resume character
  input wire uxr_pkg::uxr_byte_type  pauseChar1,   // First pause character
  input wire uxr_pkg::uxr_level_type rxTrigger,    // Receive trigger
  input wire uxr_pkg::uxr_level_type txTrigger     // Transmit trigger
);
  import uxr_pkg::*;

  // ------
  // Assertions
  // ------
  logic wrNPrev;
  logic wrEdge;

  // Write edge as the bank takes it; a held strobe writes once only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrNPrev <= 1'b1;
    end else begin
      wrNPrev <= wrN;
    end
  end
  assign wrEdge = !chanSelectN && !wrN && wrNPrev;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_sleep_div_lock: assert property (sleepEnable && wrEdge |=> $stable(baudDivisor))
    else $error("divisor written in sleep");
  a_div_byte_write: assert property ($changed(baudDivisor) |-> $past(wrEdge) && $past(addr) <= 3'h1
    && ($stable(baudDivisor[15:8]) || $stable(baudDivisor[7:0]))) else $error("divisor change without write");
  a_char_write_cause: assert property ($changed(resumeChar1) || $changed(pauseChar1)
    |-> $past(wrEdge && addr[2] && !addr[0])) else $error("flow character changed without write");
  a_mode_write_cause: assert property ($changed(flowMode) |-> $past(wrEdge && addr == 3'h2))
    else $error("enhanced byte changed without write");
  a_rx_ready_rule: assert property ($past(rstn) && $stable(rxTrigger)
    |-> rxReady == (($past(rxCount) > rxTrigger) || $past(rxTimeout))) else $error("receive ready wrong");
  a_tx_ready_rule: assert property ($past(rstn) && $stable(txTrigger)
    |-> txReady == ($past(txSpace) >= txTrigger)) else $error("transmit ready wrong");
  a_rx_trig_step: assert property ($past(rstn) |-> rxTrigger[1:0] == 2'h0 && rxTrigger != 0 && rxTrigger <= 60)
    else $error("receive trigger off grid");
  a_tx_trig_step: assert property ($past(rstn) |-> txTrigger[1:0] == 2'h0 && txTrigger != 0 && txTrigger <= 60)
    else $error("transmit trigger off grid");
endmodule

bind uxr_ext_regs uxr_ext_regs_monitor i_uxr_ext_regs_monitor (.clk(clk), .rstn(rstn), .chanSelectN(chanSelectN),
  .addr(addr), .wrN(wrN), .rxCount(rxCount), .txSpace(txSpace), .rxTimeout(rxTimeout), .rxReady(rxReady),
  .txReady(txReady), .baudDivisor(baudDivisor), .sleepEnable(sleepEnable), .flowMode(flowMode),
  .resumeChar1(resumeChar1), .pauseChar1(pauseChar1), .rxTrigger(rxTrigger), .txTrigger(txTrigger));

// File: verification/tb.sv
// Self-checking bench for the extended register bank of channel 0.
// Assumes the host model and the bound checker beside the design.
`timescale 1ns/1ps

module tb;
  import uxr_pkg::*;

  // ------
  // Signals and model state
  // ------
  logic          clk, rstn, chanSelectN, wrN, rdN, rxTimeout, rxReady, txReady, rtsN, sleepEnable, loopback;
  logic [2:0]    addr;
  logic [3:0]    peerRxReady, peerTxReady;
  logic [15:0]   baudDivisor;
  uxr_byte_type  wrData, rdData, flowMode, rc1, rc2, pc1, pc2, rd;
  uxr_level_type rxCount, txSpace, rxTrigger, txTrigger;
  uxr_byte_type  b[4];
  int            fails, check_count, seed, expRx, expTx, lvl, i;
  int            rtsIn[5] = '{19, 20, 9, 8, 21};
  int            rtsExp[5] = '{0, 1, 1, 0, 1};

  uxr_ext_regs i_uxr_ext_regs (.clk(clk), .rstn(rstn), .chanSelectN(chanSelectN), .addr(addr), .wrN(wrN),
    .rdN(rdN), .wrData(wrData), .rdData(rdData), .rxCount(rxCount), .txSpace(txSpace), .rxTimeout(rxTimeout),
    .peerRxReady(peerRxReady), .peerTxReady(peerTxReady), .rxReady(rxReady), .txReady(txReady), .rtsN(rtsN),
    .baudDivisor(baudDivisor), .sleepEnable(sleepEnable), .loopback(loopback), .flowMode(flowMode),
    .resumeChar1(rc1), .resumeChar2(rc2), .pauseChar1(pc1), .pauseChar2(pc2), .rxTrigger(rxTrigger),
    .txTrigger(txTrigger));
  uxr_host_model i_uxr_host_model (.clk(clk), .rdData(rdData), .chanSelectN(chanSelectN), .addr(addr),
    .wrN(wrN), .rdN(rdN), .wrData(wrData));

  // Clock and hang guard
  initial clk = 1'b0;
  always #10 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ready byte as the model sees it; own channel bits are recomputed
  function automatic int ready_model();
    logic [3:0] r;
    logic [3:0] t;
    r = peerRxReady;
    t = peerTxReady;
    r[0] = (rxCount > expRx) || rxTimeout;
    t[0] = txSpace >= expTx;
    return {r, t};
  endfunction

  // ------
  // Main sequence
  // ------
  initial begin
    seed = 10;
    rstn = 1'b0;
    rxCount = 7'h00;
    txSpace = 7'h00;
    rxTimeout = 1'b0;
    peerRxReady = 4'h0;
    peerTxReady = 4'h0;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    tick(2);
    chk("rtsN", 1, rtsN);
    chk("rxTrigger", 8, rxTrigger);
    for (i = 0; i < 4; i++) b[i] = $random(seed);
    // Divisor bytes through line bit seven
    i_uxr_host_model.wr(3'h3, 8'h80);
    i_uxr_host_model.wr(3'h0, b[0]);
    i_uxr_host_model.wr(3'h1, b[1]);
    i_uxr_host_model.rd(3'h0, rd);
    chk("baudDivisor", {b[1], b[0]}, baudDivisor);
    chk("divisorRead", b[0], rd);
    // Flow characters and enhanced byte under the key
    i_uxr_host_model.wr(3'h3, 8'hBF);
    for (i = 4; i < 8; i++) i_uxr_host_model.wr(3'(i), b[i - 4]);
    i_uxr_host_model.wr(3'h2, 8'h10);
    chk("resumeChar1", b[0], rc1);
    chk("resumeChar2", b[1], rc2);
    chk("pauseChar1", b[2], pc1);
    chk("pauseChar2", b[3], pc2);
    chk("flowMode", 8'h10, flowMode);
    // Trigger write refused while the bank bit is clear
    i_uxr_host_model.wr(3'h3, 8'h00);
    i_uxr_host_model.wr(3'h7, 8'h11);
    tick(2);
    chk("rxTrigger", 8, rxTrigger);
    i_uxr_host_model.rd(3'h5, rd);
    chk("unmappedRead", 0, rd);
    // Halt 20 above resume 8, then triggers 12 and 8
    i_uxr_host_model.wr(3'h4, 8'h44);
    i_uxr_host_model.wr(3'h6, 8'h25);
    i_uxr_host_model.wr(3'h7, 8'h32);
    expRx = 12;
    expTx = 8;
    tick(2);
    chk("rxTrigger", expRx, rxTrigger);
    chk("txTrigger", expTx, txTrigger);
    // Enhanced bit off: trigger write refused
    i_uxr_host_model.ext_bank(8'h00, 8'h44);
    i_uxr_host_model.wr(3'h7, 8'hFF);
    tick(2);
    chk("rxTrigger", expRx, rxTrigger);
    // Ready status around both trigger boundaries
    for (i = 0; i < 12; i++) begin
      rxCount = 7'(10 + ($random(seed) & 3));
      txSpace = 7'(6 + ($random(seed) & 3));
      rxTimeout = $random(seed);
      peerRxReady = $random(seed);
      peerTxReady = $random(seed);
      tick(3);
      lvl = ready_model();
      chk("rxReady", lvl[4], rxReady);
      chk("txReady", lvl[0], txReady);
      i_uxr_host_model.rd(3'h7, rd);
      chk("readyByte", lvl, rd);
    end
    // Loop-back hides the ready byte; then request-to-send flow on
    rxCount = 7'h00;
    i_uxr_host_model.ext_bank(8'h50, 8'h54);
    i_uxr_host_model.rd(3'h7, rd);
    chk("loopback", 1, loopback);
    chk("levelRead", 8'h32, rd);
    i_uxr_host_model.wr(3'h4, 8'h44);
    for (i = 0; i < 5; i++) begin
      rxCount = 7'(rtsIn[i]);
      tick(3);
      chk("rtsN", rtsExp[i], rtsN);
    end
    // Zero trigger fields fall back to the control selectors
    i_uxr_host_model.wr(3'h7, 8'h00);
    i_uxr_host_model.wr(3'h2, 8'hB0);
    tick(2);
    chk("rxTrigger", 56, rxTrigger);
    chk("txTrigger", 56, txTrigger);
    // Sleep locks the divisor
    i_uxr_host_model.wr(3'h1, 8'h10);
    i_uxr_host_model.wr(3'h3, 8'h80);
    i_uxr_host_model.wr(3'h0, ~b[0]);
    tick(1);
    chk("sleepEnable", 1, sleepEnable);
    chk("baudDivisor", {b[1], b[0]}, baudDivisor);
    final_report;
  end
endmodule
